// [logic/mgmt_cmd_handler.sv]
// adapter management command handler: decodes command frames, answers the six known commands only
// assumes one byte per frame field, presented with frame_valid_in for one cycle
`timescale 1ns/1ps
`default_nettype none
module mgmt_cmd_handler #(
	parameter int        dtr_low_cycles = mgmt_cmd_pkg::dtr_low_cycles,
	parameter logic [15:0] cfg_addr     = mgmt_cmd_pkg::cfg_addr_default,
	parameter logic [7:0]  cfg_rev      = mgmt_cmd_pkg::cfg_rev_default,
	parameter logic [7:0]  cfg_len      = mgmt_cmd_pkg::cfg_len_default
) (
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	input  wire logic        frame_valid_in,
	input  wire logic [7:0]  frame_sub_in,
	input  wire logic [7:0]  frame_cmd_in,
	input  wire logic [7:0]  frame_arg_in,
	input  wire logic [7:0]  frame_node_in,
	input  wire logic        nv_update_in,
	input  wire logic        attach_msg_in,
	input  wire logic        dial_in_in,
	input  wire logic [7:0]  dial_in_entry_in,
	input  wire logic        carrier_in,
	input  wire logic        hangup_str_done_in,
	output logic             resp_valid_out,
	output logic [7:0]       resp_code_out,
	output logic [15:0]      resp_addr_out,
	output logic [7:0]       resp_rev_out,
	output logic [7:0]       resp_len_out,
	output logic             owned_out,
	output logic [7:0]       owner_out,
	output logic             pool_clear_out,
	output logic             strings_empty_out,
	output logic [7:0]       nv_dial_out,
	output logic [7:0]       attach_dial_out,
	output logic             callback_en_out,
	output logic             dial_start_out,
	output logic [7:0]       dial_entry_out,
	output logic             dtr_out,
	output logic             hangup_str_send_out
);
	typedef enum logic [1:0] {hs_idle, hs_dtr_low, hs_string} hang_state_t;

	logic        owned_q;
	logic        owned_d;
	logic [7:0]  owner_q;
	logic [7:0]  owner_d;
	logic [7:0]  nv_q;
	logic [7:0]  attach_q;
	logic        cb_q;
	logic        empty_q;
	hang_state_t hs_q;
	hang_state_t hs_d;
	logic [$clog2(dtr_low_cycles+1)-1:0] dtr_cnt_q;
	logic [7:0]  cb_entry_q;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	wire logic mgmt_frame = frame_valid_in && (frame_sub_in == mgmt_cmd_pkg::sub_code_mgmt);
	wire logic is_own     = mgmt_frame && (frame_cmd_in == mgmt_cmd_pkg::cmd_own);
	wire logic is_clear   = mgmt_frame && (frame_cmd_in == mgmt_cmd_pkg::cmd_pool_clear);
	wire logic is_nv      = mgmt_frame && (frame_cmd_in == mgmt_cmd_pkg::cmd_nv_dial);
	wire logic is_attach  = mgmt_frame && (frame_cmd_in == mgmt_cmd_pkg::cmd_attach_dial);
	wire logic is_cb      = mgmt_frame && (frame_cmd_in == mgmt_cmd_pkg::cmd_callback);
	wire logic is_report  = mgmt_frame && (frame_cmd_in == mgmt_cmd_pkg::cmd_cfg_report);
	wire logic own_req    = frame_arg_in != 8'h00;
	wire logic other_node = owned_q && (owner_q != frame_node_in);
	wire logic grant      = is_own && own_req && !other_node;
	wire logic release_ok = is_own && !own_req && !other_node;
	wire logic own_fail   = is_own && other_node;
	wire logic known_cmd  = is_own || is_clear || is_nv || is_attach || is_cb || is_report;

	// ----------------------------------------------------------------
	// ownership
	// ----------------------------------------------------------------
	assign owned_d = grant ? 1'b1 : (release_ok ? 1'b0 : owned_q);
	assign owner_d = grant ? frame_node_in : owner_q;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			owned_q <= 1'b0;
			owner_q <= 8'h00;
		end else begin
			owned_q <= owned_d;
			owner_q <= owner_d;
		end
	end

	// ----------------------------------------------------------------
	// configuration bytes and string pool
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			nv_q     <= mgmt_cmd_pkg::dial_disabled;
			attach_q <= mgmt_cmd_pkg::dial_disabled;
			cb_q     <= 1'b0;
			empty_q  <= 1'b0;
		end else begin
			if (is_nv) begin
				nv_q <= frame_arg_in;
			end
			if (is_attach) begin
				attach_q <= frame_arg_in;
			end
			if (is_cb) begin
				cb_q <= frame_arg_in != mgmt_cmd_pkg::callback_reset;
			end
			if (is_clear) begin
				empty_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// responses
	// ----------------------------------------------------------------
	wire logic [7:0] resp_code_d = (own_fail || (is_own && !grant && !release_ok)) ?
		mgmt_cmd_pkg::resp_failure : mgmt_cmd_pkg::resp_success;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			resp_valid_out <= 1'b0;
			resp_code_out  <= 8'h00;
			resp_addr_out  <= 16'h0000;
			resp_rev_out   <= 8'h00;
			resp_len_out   <= 8'h00;
			pool_clear_out <= 1'b0;
		end else begin
			resp_valid_out <= known_cmd;
			pool_clear_out <= is_clear;
			if (known_cmd) begin
				resp_code_out <= resp_code_d;
				resp_addr_out <= is_report ? cfg_addr : 16'h0000;
				resp_rev_out  <= is_report ? cfg_rev : 8'h00;
				resp_len_out  <= is_report ? cfg_len : 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// dial-out triggers and callback hang-up sequence
	// ----------------------------------------------------------------
	wire logic nv_trig     = nv_update_in && (nv_q != mgmt_cmd_pkg::dial_disabled);
	wire logic attach_trig = attach_msg_in && (attach_q != mgmt_cmd_pkg::dial_disabled);
	wire logic cb_start    = dial_in_in && cb_q && (hs_q == hs_idle);
	wire logic dtr_done    = dtr_cnt_q == ($bits(dtr_cnt_q))'(dtr_low_cycles - 1);
	wire logic str_needed  = carrier_in && !empty_q;
	wire logic hang_end    = ((hs_q == hs_dtr_low) && dtr_done && !str_needed) ||
		((hs_q == hs_string) && hangup_str_done_in);

	always_comb begin
		hs_d = hs_q;
		case (hs_q)
			hs_idle: begin
				if (cb_start) begin
					hs_d = hs_dtr_low;
				end
			end
			hs_dtr_low: begin
				if (dtr_done) begin
					hs_d = str_needed ? hs_string : hs_idle;
				end
			end
			hs_string: begin
				if (hangup_str_done_in) begin
					hs_d = hs_idle;
				end
			end
			default: hs_d = hs_idle;
		endcase
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hs_q       <= hs_idle;
			dtr_cnt_q  <= '0;
			cb_entry_q <= 8'h00;
		end else begin
			hs_q      <= hs_d;
			dtr_cnt_q <= (hs_q == hs_dtr_low && !dtr_done) ? dtr_cnt_q + 1'b1 : '0;
			if (cb_start) begin
				cb_entry_q <= dial_in_entry_in;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dial_start_out      <= 1'b0;
			dial_entry_out      <= 8'h00;
			dtr_out             <= 1'b1;
			hangup_str_send_out <= 1'b0;
		end else begin
			dial_start_out      <= nv_trig || attach_trig || hang_end;
			if (hang_end) begin
				dial_entry_out <= cb_entry_q;
			end else if (nv_trig) begin
				dial_entry_out <= nv_q;
			end else if (attach_trig) begin
				dial_entry_out <= attach_q;
			end
			dtr_out             <= hs_d != hs_dtr_low;
			hangup_str_send_out <= (hs_q == hs_dtr_low) && dtr_done && str_needed;
		end
	end

	// ----------------------------------------------------------------
	// state outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			owned_out         <= 1'b0;
			owner_out         <= 8'h00;
			strings_empty_out <= 1'b0;
			nv_dial_out       <= mgmt_cmd_pkg::dial_disabled;
			attach_dial_out   <= mgmt_cmd_pkg::dial_disabled;
			callback_en_out   <= 1'b0;
		end else begin
			owned_out         <= owned_d;
			owner_out         <= owner_d;
			strings_empty_out <= empty_q || is_clear;
			nv_dial_out       <= is_nv ? frame_arg_in : nv_q;
			attach_dial_out   <= is_attach ? frame_arg_in : attach_q;
			callback_en_out   <= is_cb ? (frame_arg_in != 8'h00) : cb_q;
		end
	end
endmodule
`default_nettype wire

// [logic/mgmt_cmd_pkg.sv]
// constants for the adapter management command handler
// assumes one 200 MHz clock shared by all users of the package
package mgmt_cmd_pkg;
	localparam logic [7:0] sub_code_mgmt      = 8'h01;
	localparam logic [7:0] cmd_own            = 8'h0f;
	localparam logic [7:0] cmd_pool_clear     = 8'h10;
	localparam logic [7:0] cmd_nv_dial        = 8'h11;
	localparam logic [7:0] cmd_attach_dial    = 8'h12;
	localparam logic [7:0] cmd_callback       = 8'h13;
	localparam logic [7:0] cmd_cfg_report     = 8'h14;
	localparam logic [7:0] resp_success       = 8'h3d;
	localparam logic [7:0] resp_failure       = 8'h1d;
	localparam logic [7:0] dial_disabled      = 8'hff;
	localparam logic [7:0] callback_reset     = 8'h00;
	localparam int         clk_mhz            = 200;
	localparam int         dtr_low_ms         = 500;
	localparam int         dtr_low_cycles     = dtr_low_ms * 1000 * clk_mhz;
	localparam logic [15:0] cfg_addr_default  = 16'h0000;
	localparam logic [7:0]  cfg_rev_default   = 8'h01;
	localparam logic [7:0]  cfg_len_default   = 8'h40;
endpackage

// [tb/mgmt_cmd_handler_monitor.sv]
// port checker for the management command handler
// assumes dtr low phase of at least 8 cycles
`timescale 1ns/1ps
`default_nettype none
module mgmt_cmd_handler_monitor (
	input wire logic       mclk_in,
	input wire logic       resetn_in,
	input wire logic       frame_valid_in,
	input wire logic [7:0] frame_sub_in,
	input wire logic [7:0] frame_cmd_in,
	input wire logic [7:0] frame_arg_in,
	input wire logic [7:0] frame_node_in,
	input wire logic       resp_valid_out,
	input wire logic [7:0] resp_code_out,
	input wire logic       owned_out,
	input wire logic [7:0] owner_out,
	input wire logic       strings_empty_out,
	input wire logic [7:0] nv_dial_out,
	input wire logic       dtr_out
);
	// --------------------------------
	// assertions
	// --------------------------------
	wire fr_ok = frame_valid_in && frame_sub_in == 8'h01;
	wire own_rq = fr_ok && frame_cmd_in == 8'h0f;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	property p_resp; fr_ok && frame_cmd_in inside {[8'h0f:8'h14]} |=> resp_valid_out; endproperty
	a_resp: assert property (p_resp) else $error("no response");
	property p_grant;
		own_rq && frame_arg_in != 8'h00 && !owned_out
		|=> resp_code_out == 8'h3d && owned_out && owner_out == $past(frame_node_in);
	endproperty
	a_grant: assert property (p_grant) else $error("grant wrong");
	property p_refuse;
		own_rq && frame_arg_in != 8'h00 && owned_out && frame_node_in != owner_out
		|=> resp_code_out == 8'h1d && $stable(owner_out);
	endproperty
	a_refuse: assert property (p_refuse) else $error("refuse wrong");
	property p_rel; own_rq && frame_arg_in == 8'h00 && frame_node_in == owner_out |=> !owned_out; endproperty
	a_rel: assert property (p_rel) else $error("release wrong");
	property p_clear; fr_ok && frame_cmd_in == 8'h10 |=> strings_empty_out; endproperty
	a_clear: assert property (p_clear) else $error("pool not empty");
	property p_nv; fr_ok && frame_cmd_in == 8'h11 |=> nv_dial_out == $past(frame_arg_in); endproperty
	a_nv: assert property (p_nv) else $error("nv dial byte");
	property p_dtr; $fell(dtr_out) |-> !dtr_out [*8]; endproperty
	a_dtr: assert property (p_dtr) else $error("dtr low short");
	property p_rst; $rose(resetn_in) |-> !owned_out; endproperty
	a_rst: assert property (p_rst) else $error("owned after reset");
	c_grant: cover property (p_grant);
	c_refuse: cover property (p_refuse);
	c_dtr: cover property ($fell(dtr_out));
endmodule
bind mgmt_cmd_handler mgmt_cmd_handler_monitor u_mgmt_cmd_handler_monitor (
	.mclk_in(mclk_in), .resetn_in(resetn_in), .frame_valid_in(frame_valid_in),
	.frame_sub_in(frame_sub_in), .frame_cmd_in(frame_cmd_in), .frame_arg_in(frame_arg_in),
	.frame_node_in(frame_node_in), .resp_valid_out(resp_valid_out),
	.resp_code_out(resp_code_out), .owned_out(owned_out), .owner_out(owner_out),
	.strings_empty_out(strings_empty_out), .nv_dial_out(nv_dial_out), .dtr_out(dtr_out));
`default_nettype wire

// [tb/mgmt_node_model.sv]
// network node model: sends management frames
// assumes the handler samples frames on the rising edge
`timescale 1ns/1ps
`default_nettype none
module mgmt_node_model (
	input  wire logic       mclk_in,
	output logic            valid_out,
	output logic [7:0]      sub_out,
	output logic [7:0]      cmd_out,
	output logic [7:0]      arg_out,
	output logic [7:0]      node_out
);
	// --------------------------------
	// frame sender
	// --------------------------------
	initial {valid_out, sub_out, cmd_out, arg_out, node_out} = '0;
	task send(input logic [7:0] c, a, n);
		@(posedge mclk_in);
		#1 {valid_out, sub_out, cmd_out, arg_out, node_out} = {1'b1, 8'h01, c, a, n};
		@(posedge mclk_in);
		#1 valid_out = 1'b0;
		{sub_out, cmd_out, arg_out} = {8'h5a, 8'ha5, 8'h5a}; // idle fields carry junk
	endtask
endmodule
`default_nettype wire

// [tb/test_adapter_mgmt_command_handler.sv]
// testbench for the management command handler
// assumes a shortened dtr low phase of 16 cycles
`timescale 1ns/1ps
`default_nettype none
module test_adapter_mgmt_command_handler;
	localparam int dlc = 16;
	logic        mclk_in = 0, resetn_in = 0, carrier = 0, rv, own, pc, se, cb, ds, dtr, hs;
	logic [3:0]  ev = '0;
	logic [7:0]  entry = 8'h07, rc, rr, rl, on, nd, ad, de, fs, fc, fa, fn;
	logic [15:0] ra;
	logic        fv;
	int          n_mismatch = 0, num_checks = 0, n;
	always #2.5 mclk_in = ~mclk_in;
	mgmt_node_model u_mgmt_node_model (.mclk_in(mclk_in), .valid_out(fv), .sub_out(fs),
		.cmd_out(fc), .arg_out(fa), .node_out(fn));
	mgmt_cmd_handler #(.dtr_low_cycles(dlc)) u_mgmt_cmd_handler (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .frame_valid_in(fv), .frame_sub_in(fs), .frame_cmd_in(fc),
		.frame_arg_in(fa), .frame_node_in(fn), .nv_update_in(ev[0]), .attach_msg_in(ev[1]),
		.dial_in_in(ev[2]), .dial_in_entry_in(entry), .carrier_in(carrier),
		.hangup_str_done_in(ev[3]), .resp_valid_out(rv), .resp_code_out(rc),
		.resp_addr_out(ra), .resp_rev_out(rr), .resp_len_out(rl), .owned_out(own),
		.owner_out(on), .pool_clear_out(pc), .strings_empty_out(se), .nv_dial_out(nd),
		.attach_dial_out(ad), .callback_en_out(cb), .dial_start_out(ds),
		.dial_entry_out(de), .dtr_out(dtr), .hangup_str_send_out(hs));
	// --------------------------------
	// tasks
	// --------------------------------
	task chk(input logic [15:0] g, e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	task tick;
		@(posedge mclk_in);
		#1;
	endtask
	task cmd(input logic [7:0] c, a, nd, e);
		u_mgmt_node_model.send(c, a, nd);
		chk({15'h0, rv}, 16'h1);
		chk({8'h0, rc}, {8'h0, e});
	endtask
	task pulse(input logic [3:0] v);
		tick;
		ev = v;
		tick;
		ev = '0;
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		#10000;
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		repeat (4) @(posedge mclk_in);
		#1 resetn_in = 1;
		chk({7'h0, own, nd}, 16'h00ff);
		chk({7'h0, cb, ad}, 16'h00ff);
		pulse(4'h1);
		chk({15'h0, ds}, 16'h0);
		$display("reset test done");
		cmd(8'h0f, 8'h01, 8'h05, 8'h3d);
		chk({8'h0, on}, 16'h0005);
		cmd(8'h0f, 8'h01, 8'h06, 8'h1d);
		cmd(8'h0f, 8'h00, 8'h06, 8'h1d);
		chk({7'h0, own, on}, 16'h0105);
		cmd(8'h0f, 8'h00, 8'h05, 8'h3d);
		chk({15'h0, own}, 16'h0);
		$display("ownership test done");
		cmd(8'h11, 8'h03, 8'h06, 8'h3d);
		chk({8'h0, nd}, 16'h0003);
		pulse(4'h1);
		chk({7'h0, ds, de}, 16'h0103);
		cmd(8'h12, 8'h04, 8'h06, 8'h3d);
		chk({8'h0, ad}, 16'h0004);
		pulse(4'h2);
		chk({7'h0, ds, de}, 16'h0104);
		cmd(8'h13, 8'h02, 8'h06, 8'h3d);
		chk({15'h0, cb}, 16'h1);
		cmd(8'h14, 8'h00, 8'h06, 8'h3d);
		chk(ra, 16'h0000);
		chk({rr, rl}, 16'h0140);
		u_mgmt_node_model.send(8'h20, 8'h01, 8'h06);
		chk({15'h0, rv}, 16'h0);
		$display("config test done");
		carrier = 1;
		pulse(4'h4);
		for (n = 0; n < 100 && dtr === 1'b0; n++) tick;
		chk(16'(n), 16'(dlc));
		for (n = 0; n < 40 && hs !== 1'b1; n++) tick;
		chk({15'h0, hs}, 16'h1);
		pulse(4'h8);
		for (n = 0; n < 40 && ds !== 1'b1; n++) tick;
		chk({7'h0, ds, de}, 16'h0107);
		cmd(8'h10, 8'h00, 8'h06, 8'h3d);
		chk({14'h0, pc, se}, 16'h0003);
		entry = 8'h09;
		pulse(4'h4);
		for (n = 0; n < 40 && ds !== 1'b1; n++) tick;
		chk({6'h0, hs, ds, de}, 16'h0109);
		$display("callback test done");
		cmd(8'h0f, 8'h01, 8'h05, 8'h3d);
		resetn_in = 0;
		tick;
		resetn_in = 1;
		chk({15'h0, own}, 16'h0);
		$display("reset in mid-run test done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
